// file: pkg/rbcm_defs.svh
`ifndef RBCM_DEFS_SVH
`define RBCM_DEFS_SVH
`define RBCM_MIN_LOW_CYCLES 8
`define RBCM_STRETCH_CYCLES 1024
`define RBCM_PREDIV_RESET 3'h5
`define RBCM_PREDIV_WIDTH 3
`define RBCM_MODE_00 2'h0
`define RBCM_MODE_01 2'h1
`define RBCM_MODE_10 2'h2
`define RBCM_MODE_11 2'h3
`endif

// file: pkg/rbcm_pkg.sv
package rbcm_pkg;
  typedef enum logic [1:0] {
    RBCM_SRC_EXT_OSC,
    RBCM_SRC_ONCHIP_OSC,
    RBCM_SRC_CRYSTAL
  } rbcm_clk_src_e;

  typedef enum logic [1:0] {
    RBCM_ST_HOLD,
    RBCM_ST_STRETCH,
    RBCM_ST_RUN
  } rbcm_state_e;

  typedef struct packed {
    logic [1:0] clock_mode;
    logic crystal_level;
    logic config_n;
    logic test;
  } rbcm_straps_s;

  typedef struct packed {
    logic pll_enable;
    rbcm_clk_src_e clk_src;
    logic reserved_mode;
    logic flash_prog;
  } rbcm_boot_cfg_s;
endpackage

// file: src/rbcm_rst_qual.sv
`timescale 1ns/10ps
`default_nettype none
`include "rbcm_defs.svh"
module rbcm_rst_qual #(
  parameter int MIN_LOW = `RBCM_MIN_LOW_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reset_in_n,
  output logic qualified_q
);
  logic sync1_q;
  logic sync2_q;
  logic [$clog2(MIN_LOW+1)-1:0] low_cnt_q;

  // Two-stage synchroniser
  // reset input sync
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= reset_in_n;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_q <= '0;
      qualified_q <= 1'b0;
    end else if (sync2_q) begin
      low_cnt_q <= '0;
      qualified_q <= 1'b0;
    end else begin
      if (low_cnt_q != MIN_LOW[$bits(low_cnt_q)-1:0]) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
      qualified_q <= (low_cnt_q >= MIN_LOW[$bits(low_cnt_q)-1:0] - 1'b1);
    end
  end
endmodule // rbcm_rst_qual
`default_nettype wire

// file: src/rbcm_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rbcm_defs.svh"
module rbcm_top
  import rbcm_pkg::*;
#(
  parameter int MIN_LOW = `RBCM_MIN_LOW_CYCLES,
  parameter int STRETCH = `RBCM_STRETCH_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reset_in_n,
  input wire logic [1:0] clock_mode_straps,
  input wire logic reset_config_strap_n,
  input wire logic test_pin,
  input wire logic crystal_out_pin_i,
  input wire logic osc_amp_drive,
  input wire logic sys_clk_level,
  output logic crystal_out_pin_o,
  output logic crystal_out_pin_oe,
  output logic reset_out_n,
  output logic core_reset_n,
  output logic pll_enable,
  output rbcm_clk_src_e clock_source,
  output logic mode_reserved,
  output logic ext_clock_in_pin_en,
  output logic system_clock_out,
  output logic flash_prog_mode,
  output logic serial_flash_port_grant,
  output logic [`RBCM_PREDIV_WIDTH-1:0] pll_predivider_field
);
  localparam int CW = $clog2(STRETCH);

  rbcm_state_e state_q;
  logic [CW-1:0] stretch_cnt_q;
  logic ext_qual;
  rbcm_straps_s live_straps;
  rbcm_straps_s latched_q;
  rbcm_boot_cfg_s boot_cfg_d;
  logic release_now;

  rbcm_rst_qual #(
    .MIN_LOW(MIN_LOW)
  ) u_qual (
    .mclk(mclk),
    .resetn(resetn),
    .reset_in_n(reset_in_n),
    .qualified_q(ext_qual)
  );

  assign live_straps = '{clock_mode: clock_mode_straps, crystal_level: crystal_out_pin_i,
                         config_n: reset_config_strap_n, test: test_pin};
  assign release_now = (state_q == RBCM_ST_STRETCH) && !ext_qual &&
                       (stretch_cnt_q == CW'(STRETCH - 1));

  function automatic rbcm_boot_cfg_s decode(input rbcm_straps_s s);
    rbcm_boot_cfg_s c;
    c = '{pll_enable: 1'b0, clk_src: RBCM_SRC_EXT_OSC, reserved_mode: 1'b0,
          flash_prog: !s.config_n && !s.test};
    unique case (s.clock_mode)
      `RBCM_MODE_00: begin
        c.clk_src = s.crystal_level ? RBCM_SRC_ONCHIP_OSC : RBCM_SRC_EXT_OSC;
      end
      `RBCM_MODE_01: begin
        c.clk_src = RBCM_SRC_CRYSTAL;
      end
      `RBCM_MODE_10: begin
        c.pll_enable = !s.crystal_level;
        c.reserved_mode = s.crystal_level;
      end
      `RBCM_MODE_11: begin
        c.pll_enable = 1'b1;
        c.clk_src = RBCM_SRC_CRYSTAL;
      end
    endcase
    return c;
  endfunction

  assign boot_cfg_d = decode(live_straps);

  // Reset sequencing
  // hold and stretch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= RBCM_ST_STRETCH;
      stretch_cnt_q <= '0;
    end else if (ext_qual) begin
      state_q <= RBCM_ST_HOLD;
      stretch_cnt_q <= '0;
    end else begin
      unique case (state_q)
        RBCM_ST_HOLD: begin
          state_q <= RBCM_ST_STRETCH;
        end
        RBCM_ST_STRETCH: begin
          stretch_cnt_q <= stretch_cnt_q + 1'b1;
          if (release_now) begin
            state_q <= RBCM_ST_RUN;
          end
        end
        RBCM_ST_RUN: begin
          state_q <= RBCM_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reset_out_n <= 1'b0;
      core_reset_n <= 1'b0;
    end else begin
      reset_out_n <= (state_q == RBCM_ST_RUN && !ext_qual) || release_now;
      core_reset_n <= (state_q == RBCM_ST_RUN && !ext_qual) || release_now;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latched_q <= '{clock_mode: 2'h0, crystal_level: 1'b0, config_n: 1'b1, test: 1'b0};
      pll_enable <= 1'b0;
      clock_source <= RBCM_SRC_EXT_OSC;
      mode_reserved <= 1'b0;
      flash_prog_mode <= 1'b0;
      serial_flash_port_grant <= 1'b0;
      ext_clock_in_pin_en <= 1'b1;
    end else if (release_now) begin
      latched_q <= live_straps;
      pll_enable <= boot_cfg_d.pll_enable;
      clock_source <= boot_cfg_d.clk_src;
      mode_reserved <= boot_cfg_d.reserved_mode;
      flash_prog_mode <= boot_cfg_d.flash_prog;
      serial_flash_port_grant <= boot_cfg_d.flash_prog;
      ext_clock_in_pin_en <= (boot_cfg_d.clk_src != RBCM_SRC_ONCHIP_OSC);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      crystal_out_pin_oe <= 1'b0;
      crystal_out_pin_o <= 1'b0;
    end else begin
      crystal_out_pin_oe <= (state_q == RBCM_ST_RUN) ? latched_q.clock_mode[0]
                                                    : clock_mode_straps[0];
      crystal_out_pin_o <= osc_amp_drive;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      system_clock_out <= 1'b0;
    end else begin
      system_clock_out <= sys_clk_level;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pll_predivider_field <= `RBCM_PREDIV_RESET;
    end else begin
      pll_predivider_field <= `RBCM_PREDIV_RESET;
    end
  end

  // Checks
  sequence s_release;
    $rose(reset_out_n);
  endsequence

  sequence s_ext_low;
    ext_qual;
  endsequence

  int unsigned low_run_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_run_q <= 0;
    end else if (reset_out_n || state_q == RBCM_ST_HOLD) begin
      low_run_q <= 0;
    end else begin
      low_run_q <= low_run_q + 1;
    end
  end

  stretch_len_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_release |-> $past(low_run_q) == STRETCH - 1)
    else $error("reset output stretch length wrong");

  hold_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_ext_low |=> !reset_out_n && !core_reset_n)
    else $error("qualified reset did not drive resets low");

  in_qual_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!reset_in_n)[*8] ##1 (!reset_in_n)[*3] |-> ext_qual)
    else $error("reset input held low not qualified");

  latch_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    release_now |=> latched_q.clock_mode == $past(clock_mode_straps))
    else $error("straps not latched at release");

  pll_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    release_now && clock_mode_straps == `RBCM_MODE_11 |=>
      pll_enable && clock_source == RBCM_SRC_CRYSTAL)
    else $error("mode 11 decode wrong");

  onchip_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    release_now && clock_mode_straps == `RBCM_MODE_00 && crystal_out_pin_i |=>
      !pll_enable && clock_source == RBCM_SRC_ONCHIP_OSC && !ext_clock_in_pin_en)
    else $error("mode 00 high decode wrong");

  reserved_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    release_now && clock_mode_straps == `RBCM_MODE_10 |=>
      pll_enable == !$past(crystal_out_pin_i) && mode_reserved == $past(crystal_out_pin_i))
    else $error("mode 10 decode wrong");

  crystal_out_pin_dir_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q != RBCM_ST_RUN && !clock_mode_straps[0] |=> !crystal_out_pin_oe)
    else $error("crystal pin driven while sampled");

  flash_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    release_now |=> flash_prog_mode == (!$past(reset_config_strap_n) && !$past(test_pin)))
    else $error("flash programming entry wrong");

  prediv_a: assert property (@(posedge mclk) disable iff (!resetn)
    pll_predivider_field == `RBCM_PREDIV_RESET)
    else $error("pre-divider not at reset value");

  system_clock_out_a: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 system_clock_out == $past(sys_clk_level))
    else $error("clock output not a copy");
endmodule // rbcm_top
`default_nettype wire

// file: verification/rbcm_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module rbcm_board_model (
  input wire logic mclk,
  output logic reset_in_n,
  output logic [1:0] clock_mode_straps,
  output logic reset_config_strap_n,
  output logic test_pin,
  output logic crystal_out_pin_level
);
  initial begin
    reset_in_n = 1'h1;
    clock_mode_straps = 2'h0;
    reset_config_strap_n = 1'h1;
    test_pin = 1'h0;
    crystal_out_pin_level = 1'h0;
  end

  task automatic pulse(input int n, input logic [1:0] m, input logic x, c, t);
    @(posedge mclk);
    clock_mode_straps <= m;
    crystal_out_pin_level <= x;
    reset_config_strap_n <= c;
    test_pin <= t;
    reset_in_n <= 1'h0;
    repeat (n) @(posedge mclk);
    reset_in_n <= 1'h1;
  endtask
endmodule // rbcm_board_model
`default_nettype wire

// file: verification/rbcm_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rbcm_top_bench;
  import rbcm_pkg::*;
  localparam int STRETCH = 16;
  logic mclk;
  logic resetn;
  logic osc_amp_drive;
  logic sys_clk_level;
  logic reset_in_n;
  logic [1:0] clock_mode_straps;
  logic reset_config_strap_n;
  logic test_pin;
  logic crystal_out_pin_level;
  logic crystal_out_pin_pin;
  logic crystal_out_pin_o;
  logic crystal_out_pin_oe;
  logic reset_out_n;
  logic core_reset_n;
  logic pll_enable;
  rbcm_clk_src_e clock_source;
  logic mode_reserved;
  logic ext_clock_in_pin_en;
  logic system_clock_out;
  logic flash_prog_mode;
  logic serial_flash_port_grant;
  logic [2:0] pll_predivider_field;
  int errors;
  int comparisons;

  assign crystal_out_pin_pin = crystal_out_pin_oe ? crystal_out_pin_o : crystal_out_pin_level;

  rbcm_board_model board (.mclk(mclk), .reset_in_n(reset_in_n),
    .clock_mode_straps(clock_mode_straps), .reset_config_strap_n(reset_config_strap_n),
    .test_pin(test_pin), .crystal_out_pin_level(crystal_out_pin_level));

  rbcm_top #(.MIN_LOW(8), .STRETCH(STRETCH)) DUT (.mclk(mclk), .resetn(resetn),
    .reset_in_n(reset_in_n), .clock_mode_straps(clock_mode_straps),
    .reset_config_strap_n(reset_config_strap_n), .test_pin(test_pin),
    .crystal_out_pin_i(crystal_out_pin_pin), .osc_amp_drive(osc_amp_drive),
    .sys_clk_level(sys_clk_level), .crystal_out_pin_o(crystal_out_pin_o),
    .crystal_out_pin_oe(crystal_out_pin_oe), .reset_out_n(reset_out_n),
    .core_reset_n(core_reset_n), .pll_enable(pll_enable), .clock_source(clock_source),
    .mode_reserved(mode_reserved), .ext_clock_in_pin_en(ext_clock_in_pin_en),
    .system_clock_out(system_clock_out), .flash_prog_mode(flash_prog_mode),
    .serial_flash_port_grant(serial_flash_port_grant),
    .pll_predivider_field(pll_predivider_field));

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    sys_clk_level <= ~sys_clk_level;
    osc_amp_drive <= ~osc_amp_drive;
  end

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  task automatic wait_release(output int n);
    n = 0;
    while (reset_out_n !== 1'h1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  task automatic power_on;
    int n;
    chk("prediv", 16'h5, pll_predivider_field);
    chk("rst_out", 16'h0, reset_out_n);
    @(posedge mclk);
    resetn <= 1'h1;
    #1;
    wait_release(n);
    chk("por_stretch", STRETCH, n);
    chk("prediv_run", 16'h5, pll_predivider_field);
  endtask

  task automatic mode_case(input logic [1:0] m, input logic x, c, t, p,
                           input rbcm_clk_src_e s, input logic r, e, f);
    int n;
    board.pulse(12, m, x, c, t);
    #1;
    chk("core_rst", 16'h0, core_reset_n);
    @(posedge mclk);
    #1;
    chk("crystal_out_pin_oe", m[0], crystal_out_pin_oe);
    wait_release(n);
    chk("stretch", STRETCH + 3, n);
    chk("pll", p, pll_enable);
    chk("src", s, clock_source);
    chk("reserved", r, mode_reserved);
    chk("ext_clock_in_pin_en", e, ext_clock_in_pin_en);
    chk("flash", f, flash_prog_mode);
    chk("grant", f, serial_flash_port_grant);
    chk("core_up", 16'h1, core_reset_n);
  endtask

  task automatic restart;
    int n;
    board.pulse(12, 2'h3, 1'h0, 1'h1, 1'h0);
    repeat (4) @(posedge mclk);
    board.pulse(12, 2'h3, 1'h0, 1'h1, 1'h0);
    #1;
    wait_release(n);
    chk("restart", STRETCH + 4, n);
  endtask

  task automatic short_pulse;
    logic fell;
    fell = 1'h0;
    board.pulse(5, 2'h3, 1'h0, 1'h1, 1'h0);
    repeat (30) begin
      @(posedge mclk);
      #1;
      if (reset_out_n !== 1'h1) fell = 1'h1;
    end
    chk("short_ignored", 16'h0, fell);
  endtask

  task automatic clock_copy;
    logic v;
    logic w;
    @(posedge mclk);
    v = sys_clk_level;
    w = osc_amp_drive;
    #1;
    chk("system_clock_out", v, system_clock_out);
    chk("crystal_out_pin_out", w, crystal_out_pin_o);
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    resetn = 1'h0;
    sys_clk_level = 1'h0;
    osc_amp_drive = 1'h0;
    errors = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    #1;
    power_on();
    mode_case(2'h0, 1'h0, 1'h1, 1'h0, 1'h0, RBCM_SRC_EXT_OSC, 1'h0, 1'h1, 1'h0);
    mode_case(2'h0, 1'h1, 1'h1, 1'h0, 1'h0, RBCM_SRC_ONCHIP_OSC, 1'h0, 1'h0, 1'h0);
    mode_case(2'h1, 1'h0, 1'h1, 1'h0, 1'h0, RBCM_SRC_CRYSTAL, 1'h0, 1'h1, 1'h0);
    mode_case(2'h2, 1'h0, 1'h0, 1'h0, 1'h1, RBCM_SRC_EXT_OSC, 1'h0, 1'h1, 1'h1);
    mode_case(2'h2, 1'h1, 1'h1, 1'h0, 1'h0, RBCM_SRC_EXT_OSC, 1'h1, 1'h1, 1'h0);
    mode_case(2'h3, 1'h1, 1'h0, 1'h1, 1'h1, RBCM_SRC_CRYSTAL, 1'h0, 1'h1, 1'h0);
    restart();
    short_pulse();
    clock_copy();
    clock_copy();
    wrap_up();
  end

  initial begin
    #100000;
    errors++;
    wrap_up();
  end
endmodule // rbcm_top_bench
`default_nettype wire
